/* shared/cebi_pkg.sv */
package cebi_pkg;

  localparam logic [19:0] RESET_FETCH_ADDR = 20'hffff0;
  localparam int          FIFO_WIDTH       = 8;
  localparam int          FIFO_DEPTH       = 32;
  localparam int          FIFO_CNT_W       = 6;
  // prefetch stops here even though the buffer is deeper
  localparam logic [5:0]  QUEUE_LIMIT      = 6'h04;
  localparam logic [7:0]  NMI_TYPE         = 8'h02;
  localparam logic [9:0]  PTR_HIGH_ZERO    = 10'h000;
  localparam logic [1:0]  PTR_LOW_ZERO     = 2'h0;

  typedef enum logic [6:0] {
    BS_IDLE = 7'h01,
    BS_T1   = 7'h02,
    BS_T2   = 7'h04,
    BS_T3   = 7'h08,
    BS_TW   = 7'h10,
    BS_T4   = 7'h20,
    BS_HOLD = 7'h40
  } cebi_bus_state_t;

  // codes equal the cycle-type pin encoding, msb first
  typedef enum logic [2:0] {
    CK_INT_ACK_STROBE_N    = 3'h0,
    CK_IO_RD   = 3'h1,
    CK_IO_WR   = 3'h2,
    CK_HALT    = 3'h3,
    CK_FETCH   = 3'h4,
    CK_MEM_RD  = 3'h5,
    CK_MEM_WR  = 3'h6,
    CK_PASSIVE = 3'h7
  } cebi_kind_t;

  // bit 1 is segment_status_hi, bit 0 segment_status_lo
  typedef enum logic [1:0] {
    SEG_ALT   = 2'h0,
    SEG_STACK = 2'h1,
    SEG_CODE  = 2'h2,
    SEG_DATA  = 2'h3
  } cebi_seg_t;

  typedef enum logic [1:0] {
    QS_NOP   = 2'h0,
    QS_FIRST = 2'h1,
    QS_EMPTY = 2'h2,
    QS_NEXT  = 2'h3
  } cebi_qstate_t;

  typedef enum logic [1:0] {
    HS_NONE   = 2'h0,
    HS_PIN    = 2'h1,
    HS_LINE_A = 2'h2,
    HS_LINE_B = 2'h3
  } cebi_hold_src_t;

  typedef enum logic [1:0] {
    HP_FLOAT = 2'h0,
    HP_GRANT = 2'h1,
    HP_HELD  = 2'h2
  } cebi_hold_phase_t;

  typedef struct packed {
    cebi_kind_t  kind;
    logic [19:0] addr;
    cebi_seg_t   seg;
    logic [7:0]  wdata;
  } cebi_req_t;

  typedef struct packed {
    logic [7:0] ad_out;
    logic       ad_oe;
    logic [7:0] mid;
    logic       mid_oe;
    logic [3:0] upper;
    logic       upper_oe;
    logic       rd_n;
    logic       rd_oe;
    logic       wr_n;
    logic       wr_oe;
    logic       int_ack_strobe_n_n;
    logic       int_ack_strobe_n_oe;
    logic       ale;
    logic       space;
    logic       space_oe;
    logic       dir;
    logic       den_n;
    logic       xcvr_oe;
    logic       hold_grant;
    logic       ss0;
    logic [2:0] ctype;
    logic       ctype_oe;
    logic       lock_n;
    logic       lock_oe;
    logic [1:0] qstate;
    logic       rga_out;
    logic       rga_oe;
    logic       rgb_out;
    logic       rgb_oe;
  } cebi_pins_t;

endpackage

/* src/cebi_bus_interface.sv */
`timescale 1ns/1ps
// Behaviour
// RULE1: ready low at end of T3 or wait state inserts another wait state.
// RULE2: interrupt acknowledge is two back-to-back cycles with low lines floating.
// RULE3: low lines carry address in T1, data afterwards, float in ack/hold.
// RULE4: middle address holds bits 8..15 all cycle, floats in ack/hold.
// RULE5: upper lines give address in T1, zero for I/O, then status.
// RULE6: status carries segment code and interrupt-enable flag.
// RULE7: read, write and acknowledge strobes are active low, float in hold.
// RULE8: maskable request synchronised, taken at instruction boundary if enabled.
// RULE9: wait instruction idles while test input is high.
// RULE10: non-maskable input synchronised, becomes type 2, source holds two clocks.
// RULE11: reset restarts the unit at once; source holds it four clocks.
// RULE12: configuration select high gives minimum, low gives maximum configuration.
// RULE13: maximum configuration emits the three-bit cycle type, floats in hold.
// RULE14: maximum configuration hands the bus over two request/grant lines.
// RULE15: maximum configuration drives active-low bus lock, floats in hold.
// RULE16: queue state shows nop, first byte, emptied, subsequent byte.
// RULE17: space select low for memory, high for I/O, floats in hold.
// RULE18: address strobe pulses high in T1 and never floats.
// RULE19: transceiver direction high transmit, enable low active, float in hold.
// RULE20: minimum configuration hold request answered by hold grant.
// RULE21: prefetch keeps at most four instruction bytes queued.
// RULE22: first fetch after reset at ffff0; pointer table below 400 hex.
// RULE23: each cycle is T1 to T4 with wait states between T3 and T4.
// RULE24: strobes assert at start of T2, release at start of T4.
// RULE25: lock spans first to second acknowledge T2; type times four.
// RULE26: hold finishes cycle, floats bus, then grants until request drops.

module cebi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  flush_in,
  input  wire logic                  in_valid_in,
  output logic                       in_ready_out,
  input  wire logic [WIDTH-1:0]      in_data_in,
  output logic                       out_valid_out,
  input  wire logic                  out_ready_in,
  output logic [WIDTH-1:0]           out_data_out,
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } cebi_fifo_st_t;

  cebi_fifo_st_t    r;
  cebi_fifo_st_t    next_r;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_out  = (r.cnt != CW'(DEPTH));
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out  = mem[r.rd];
  assign count_out     = r.cnt;
  assign push          = in_valid_in & in_ready_out & ~flush_in;
  assign pop           = out_valid_out & out_ready_in & ~flush_in;

  always_comb begin
    next_r = r;
    if (flush_in) begin
      next_r = '0;
    end else begin
      if (push) begin
        next_r.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : AW'(r.wr + 1'b1);
      end
      if (pop) begin
        next_r.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : AW'(r.rd + 1'b1);
      end
      next_r.cnt = CW'(r.cnt + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // storage has no reset; occupancy guards every read
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[r.wr] <= in_data_in;
    end
  end
endmodule

module cebi_bus_interface (
  input  wire logic                 ref_clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 config_select_in,
  input  wire logic                 ready_in,
  input  wire logic                 maskable_irq_in,
  input  wire logic                 nmi_in,
  input  wire logic                 test_in,
  input  wire logic                 hold_in,
  input  wire logic                 req_grant_a_in,
  input  wire logic                 req_grant_b_in,
  input  wire logic [7:0]           mux_addr_data_in,
  output cebi_pkg::cebi_pins_t      pins_out,
  input  wire cebi_pkg::cebi_req_t  eu_req_in,
  input  wire logic                 eu_req_valid_in,
  output logic                      eu_req_ready_out,
  input  wire logic                 irq_enable_in,
  input  wire logic                 instr_boundary_in,
  input  wire logic                 wait_instr_in,
  input  wire logic                 flush_in,
  input  wire logic [19:0]          flush_addr_in,
  input  wire logic                 queue_ready_in,
  input  wire logic                 queue_first_in,
  output logic [7:0]                queue_byte_out,
  output logic                      queue_valid_out,
  output logic [7:0]                rdata_out,
  output logic                      rdata_valid_out,
  output logic [19:0]               int_ptr_out,
  output logic                      int_ptr_valid_out,
  output logic                      irq_take_out,
  output logic                      nmi_take_out,
  output logic                      wait_idle_out
);
  typedef struct packed {
    cebi_pkg::cebi_bus_state_t  st;
    cebi_pkg::cebi_req_t        cyc;
    logic                       fetching;
    logic                       discard;
    logic                       int_ack_strobe_n_pend;
    logic                       int_ack_strobe_n_second;
    logic                       lock;
    cebi_pkg::cebi_hold_src_t   hsrc;
    cebi_pkg::cebi_hold_phase_t hphase;
    logic [19:0]                code_addr;
    logic                       nmi_s1;
    logic                       nmi_s2;
    logic                       nmi_s3;
    logic                       irq_s1;
    logic                       irq_s2;
    logic                       nmi_pend;
    logic [7:0]                 rdata;
    logic                       rdata_valid;
    logic [19:0]                int_ptr;
    logic                       int_ptr_valid;
    logic                       irq_take;
    logic                       nmi_take;
    cebi_pkg::cebi_qstate_t     qstate;
    logic                       wait_idle;
    cebi_pkg::cebi_pins_t       pins;
  } cebi_core_t;

  cebi_core_t                      r;
  cebi_core_t                      next_r;
  logic                            mn;
  logic                            decide;
  logic                            hold_req;
  logic                            done;
  logic                            q_in_ready;
  logic                            q_push;
  logic [cebi_pkg::FIFO_CNT_W-1:0] q_count;

  assign mn       = config_select_in;                              // RULE12
  assign decide   = (r.st == cebi_pkg::BS_IDLE) | (r.st == cebi_pkg::BS_T4);
  // grant lines only count as requests while nobody holds the bus
  assign hold_req = mn ? hold_in : (~req_grant_a_in | ~req_grant_b_in);
  assign done     = ((r.st == cebi_pkg::BS_T3) | (r.st == cebi_pkg::BS_TW))
                    & (ready_in | (r.cyc.kind == cebi_pkg::CK_HALT));
  assign q_push   = done & r.fetching & ~r.discard & ~flush_in;
  assign eu_req_ready_out = decide & ~(hold_req & ~r.lock) & ~r.int_ack_strobe_n_pend;

  cebi_fifo #(
    .WIDTH(cebi_pkg::FIFO_WIDTH),
    .DEPTH(cebi_pkg::FIFO_DEPTH)
  ) u_queue (
    .ref_clk_in    (ref_clk_in),
    .reset_in      (reset_in),
    .flush_in      (flush_in),
    .in_valid_in   (q_push),
    .in_ready_out  (q_in_ready),
    .in_data_in    (mux_addr_data_in),
    .out_valid_out (queue_valid_out),
    .out_ready_in  (queue_ready_in),
    .out_data_out  (queue_byte_out),
    .count_out     (q_count)
  );

  function automatic cebi_pkg::cebi_pins_t drive(cebi_core_t s, logic m,
                                                  logic ien);
    cebi_pkg::cebi_pins_t p;
    logic t1, strobe, data, act, hold, int_ack_strobe_n, rdk, wrk, io;
    t1     = (s.st == cebi_pkg::BS_T1);
    strobe = (s.st == cebi_pkg::BS_T2) | (s.st == cebi_pkg::BS_T3)
             | (s.st == cebi_pkg::BS_TW);
    data   = strobe | (s.st == cebi_pkg::BS_T4);
    act    = t1 | data;
    hold   = (s.st == cebi_pkg::BS_HOLD);
    int_ack_strobe_n   = act & (s.cyc.kind == cebi_pkg::CK_INT_ACK_STROBE_N);
    rdk    = (s.cyc.kind == cebi_pkg::CK_IO_RD)
             | (s.cyc.kind == cebi_pkg::CK_MEM_RD)
             | (s.cyc.kind == cebi_pkg::CK_FETCH);
    wrk    = (s.cyc.kind == cebi_pkg::CK_IO_WR)
             | (s.cyc.kind == cebi_pkg::CK_MEM_WR);
    io     = (s.cyc.kind == cebi_pkg::CK_IO_RD)
             | (s.cyc.kind == cebi_pkg::CK_IO_WR) | int_ack_strobe_n;
    p.ad_out   = t1 ? s.cyc.addr[7:0] : s.cyc.wdata;                // RULE3
    p.ad_oe    = act & ~int_ack_strobe_n & (t1 | (data & wrk));                 // RULE2
    p.mid      = s.cyc.addr[15:8];                                  // RULE4
    p.mid_oe   = ~hold & ~int_ack_strobe_n;                                     // RULE4
    p.upper    = t1 ? (io ? 4'h0 : s.cyc.addr[19:16])               // RULE5
                    : {1'b0, ien, s.cyc.seg};                       // RULE6
    p.upper_oe = ~hold;                                             // RULE5
    p.rd_n     = ~(strobe & rdk);                                   // RULE24
    p.rd_oe    = ~hold;                                             // RULE7
    p.wr_n     = ~(strobe & wrk);                                   // RULE24
    p.wr_oe    = m & ~hold;                                         // RULE7
    p.int_ack_strobe_n_n   = ~(strobe & int_ack_strobe_n);                                  // RULE24
    p.int_ack_strobe_n_oe  = m & ~hold;                                         // RULE7
    p.ale      = m & t1;                                            // RULE18
    p.space    = act & io;                                          // RULE17
    p.space_oe = m & ~hold;                                         // RULE17
    p.dir      = ~(act & (rdk | int_ack_strobe_n));                             // RULE19
    p.den_n    = ~(data & (s.cyc.kind != cebi_pkg::CK_HALT));      // RULE19
    p.xcvr_oe  = m & ~hold;                                         // RULE19
    p.hold_grant = m & hold & (s.hphase == cebi_pkg::HP_GRANT);    // RULE20
    p.ctype    = (t1 | strobe) ? s.cyc.kind : cebi_pkg::CK_PASSIVE; // RULE13
    p.ctype_oe = ~m & ~hold;                                        // RULE13
    p.ss0      = p.ctype[0];
    p.lock_n   = ~s.lock;                                           // RULE15
    p.lock_oe  = ~m & ~hold;                                        // RULE15
    p.qstate   = s.qstate;                                          // RULE16
    // grant is a one-clock low pulse on the requesting line
    p.rga_out  = 1'b0;
    p.rga_oe   = ~m & hold & (s.hphase == cebi_pkg::HP_GRANT)
                 & (s.hsrc == cebi_pkg::HS_LINE_A);                 // RULE14
    p.rgb_out  = 1'b0;
    p.rgb_oe   = ~m & hold & (s.hphase == cebi_pkg::HP_GRANT)
                 & (s.hsrc == cebi_pkg::HS_LINE_B);                 // RULE14
    return p;
  endfunction

  always_comb begin
    next_r = r;
    next_r.rdata_valid   = 1'b0;
    next_r.int_ptr_valid = 1'b0;
    next_r.irq_take      = 1'b0;
    next_r.nmi_take      = 1'b0;
    next_r.qstate        = cebi_pkg::QS_NOP;
    next_r.nmi_s1 = nmi_in;                                         // RULE10
    next_r.nmi_s2 = r.nmi_s1;
    next_r.nmi_s3 = r.nmi_s2;
    next_r.irq_s1 = maskable_irq_in;                                // RULE8
    next_r.irq_s2 = r.irq_s1;
    next_r.wait_idle = wait_instr_in & test_in;                     // RULE9

    // non-maskable wins over maskable at the same boundary
    if (instr_boundary_in & r.nmi_pend) begin
      next_r.nmi_take      = 1'b1;
      next_r.nmi_pend      = 1'b0;
      next_r.int_ptr       = {cebi_pkg::PTR_HIGH_ZERO, cebi_pkg::NMI_TYPE,
                              cebi_pkg::PTR_LOW_ZERO};              // RULE10
      next_r.int_ptr_valid = 1'b1;
    end else if (instr_boundary_in & r.irq_s2 & irq_enable_in
                 & ~r.int_ack_strobe_n_pend) begin
      next_r.irq_take  = 1'b1;                                      // RULE8
      next_r.int_ack_strobe_n_pend = 1'b1;
    end
    if (r.nmi_s2 & ~r.nmi_s3) begin
      next_r.nmi_pend = 1'b1;
    end

    case (r.st)
      cebi_pkg::BS_T1: begin
        next_r.st = cebi_pkg::BS_T2;
        if (r.cyc.kind == cebi_pkg::CK_INT_ACK_STROBE_N) begin
          next_r.lock = ~r.int_ack_strobe_n_second;                             // RULE25
        end
      end
      cebi_pkg::BS_T2: begin
        next_r.st = cebi_pkg::BS_T3;
      end
      cebi_pkg::BS_T3, cebi_pkg::BS_TW: begin
        if (done) begin
          next_r.st = cebi_pkg::BS_T4;                              // RULE23
          next_r.fetching = 1'b0;
          next_r.discard  = 1'b0;
          if (r.cyc.kind == cebi_pkg::CK_INT_ACK_STROBE_N) begin
            next_r.int_ack_strobe_n_second = ~r.int_ack_strobe_n_second;                    // RULE2
            if (r.int_ack_strobe_n_second) begin
              next_r.int_ack_strobe_n_pend     = 1'b0;
              next_r.int_ptr       = {cebi_pkg::PTR_HIGH_ZERO,
                                      mux_addr_data_in,
                                      cebi_pkg::PTR_LOW_ZERO};      // RULE25
              next_r.int_ptr_valid = 1'b1;
            end
          end else if (~r.fetching & (r.cyc.kind != cebi_pkg::CK_HALT)) begin
            next_r.rdata       = mux_addr_data_in;
            next_r.rdata_valid = (r.cyc.kind == cebi_pkg::CK_IO_RD)
                                 | (r.cyc.kind == cebi_pkg::CK_MEM_RD);
          end
        end else begin
          next_r.st = cebi_pkg::BS_TW;                              // RULE1
        end
      end
      cebi_pkg::BS_HOLD: begin
        case (r.hphase)
          cebi_pkg::HP_FLOAT: begin
            next_r.hphase = cebi_pkg::HP_GRANT;                     // RULE26
          end
          cebi_pkg::HP_GRANT: begin
            if (r.hsrc != cebi_pkg::HS_PIN) begin
              next_r.hphase = cebi_pkg::HP_HELD;                    // RULE14
            end else if (~hold_in) begin
              next_r.st   = cebi_pkg::BS_IDLE;                      // RULE26
              next_r.hsrc = cebi_pkg::HS_NONE;
            end
          end
          default: begin
            // release pulse from the master that holds the bus
            if (((r.hsrc == cebi_pkg::HS_LINE_A) & ~req_grant_a_in)
                | ((r.hsrc == cebi_pkg::HS_LINE_B) & ~req_grant_b_in)) begin
              next_r.st   = cebi_pkg::BS_IDLE;
              next_r.hsrc = cebi_pkg::HS_NONE;
            end
          end
        endcase
      end
      default: begin
        next_r.st = cebi_pkg::BS_IDLE;
      end
    endcase

    if (decide) begin
      next_r.st = cebi_pkg::BS_IDLE;
      if (hold_req & ~r.lock) begin
        next_r.st     = cebi_pkg::BS_HOLD;                          // RULE26
        next_r.hphase = cebi_pkg::HP_FLOAT;
        next_r.hsrc   = mn ? cebi_pkg::HS_PIN
                      : (~req_grant_a_in ? cebi_pkg::HS_LINE_A
                                         : cebi_pkg::HS_LINE_B);
      end else if (r.int_ack_strobe_n_pend) begin
        next_r.st       = cebi_pkg::BS_T1;                          // RULE2
        next_r.cyc.kind = cebi_pkg::CK_INT_ACK_STROBE_N;
      end else if (eu_req_valid_in) begin
        next_r.st  = cebi_pkg::BS_T1;
        next_r.cyc = eu_req_in;
      end else if (q_in_ready & (q_count < cebi_pkg::QUEUE_LIMIT)) begin
        next_r.st        = cebi_pkg::BS_T1;                         // RULE21
        next_r.cyc.kind  = cebi_pkg::CK_FETCH;
        next_r.cyc.addr  = r.code_addr;                             // RULE22
        next_r.cyc.seg   = cebi_pkg::SEG_CODE;
        next_r.fetching  = 1'b1;
        next_r.code_addr = r.code_addr + 20'h1;
      end
    end

    if (flush_in) begin
      next_r.qstate    = cebi_pkg::QS_EMPTY;                        // RULE16
      next_r.code_addr = flush_addr_in;
      next_r.discard   = next_r.fetching;
    end else if (queue_valid_out & queue_ready_in) begin
      next_r.qstate = queue_first_in ? cebi_pkg::QS_FIRST
                                     : cebi_pkg::QS_NEXT;           // RULE16
    end

    next_r.pins = drive(next_r, mn, irq_enable_in);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      r           <= '0;                                            // RULE11
      r.st        <= cebi_pkg::BS_IDLE;
      r.cyc.kind  <= cebi_pkg::CK_PASSIVE;
      r.code_addr <= cebi_pkg::RESET_FETCH_ADDR;                    // RULE22
      r.pins      <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pins_out          = r.pins;
  assign rdata_out         = r.rdata;
  assign rdata_valid_out   = r.rdata_valid;
  assign int_ptr_out       = r.int_ptr;
  assign int_ptr_valid_out = r.int_ptr_valid;
  assign irq_take_out      = r.irq_take;
  assign nmi_take_out      = r.nmi_take;
  assign wait_idle_out     = r.wait_idle;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_not_ready_t3;
    r.st == cebi_pkg::BS_T3 && !ready_in
      && r.cyc.kind != cebi_pkg::CK_HALT;
  endsequence
  sequence s_int_ack_strobe_n_first_t1;
    r.st == cebi_pkg::BS_T1 && r.cyc.kind == cebi_pkg::CK_INT_ACK_STROBE_N
      && !r.int_ack_strobe_n_second;
  endsequence
  sequence s_nmi_pulse;
    $rose(nmi_in) ##1 nmi_in;
  endsequence

  a_wait_on_ready: assert property (s_not_ready_t3 |=> r.st == cebi_pkg::BS_TW) // RULE1
    else $error("no wait state after ready low");
  a_int_ack_strobe_n_float: assert property (s_int_ack_strobe_n_first_t1 |-> !pins_out.ad_oe [*8]) // RULE2
    else $error("low lines driven during acknowledge");
  a_addr_in_t1: assert property (r.st == cebi_pkg::BS_T1 && r.cyc.kind
      != cebi_pkg::CK_INT_ACK_STROBE_N |-> pins_out.ad_oe
      && pins_out.ad_out == r.cyc.addr[7:0]) // RULE3
    else $error("address missing in T1");
  a_io_upper_low: assert property (r.st == cebi_pkg::BS_T1
      && r.cyc.kind == cebi_pkg::CK_IO_RD |-> pins_out.upper == 4'h0) // RULE5
    else $error("upper address not low for I/O");
  a_strobe_span: assert property (r.st == cebi_pkg::BS_T1 && mn
      && r.cyc.kind == cebi_pkg::CK_MEM_RD |=> !pins_out.rd_n
      ##1 !pins_out.rd_n) // RULE24
    else $error("read strobe not active in T2 and T3");
  a_strobe_off_t4: assert property (r.st == cebi_pkg::BS_T4
      |-> pins_out.rd_n && pins_out.wr_n && pins_out.int_ack_strobe_n_n) // RULE24
    else $error("strobe still active in T4");
  a_lock_int_ack_strobe_n: assert property (s_int_ack_strobe_n_first_t1 |=> r.lock
      ##[1:300] (r.st == cebi_pkg::BS_T1 && r.int_ack_strobe_n_second)) // RULE25
    else $error("lock not held between acknowledge cycles");
  a_hold_floats: assert property ($rose(pins_out.hold_grant)
      |-> !pins_out.ad_oe && !pins_out.upper_oe
      && $past(r.st == cebi_pkg::BS_HOLD)) // RULE26
    else $error("grant before bus floated");
  a_nmi_pending: assert property (s_nmi_pulse |-> ##[1:3] r.nmi_pend
      || r.nmi_take) // RULE10
    else $error("non-maskable pulse lost");
  a_queue_limit: assert property (q_count <= cebi_pkg::QUEUE_LIMIT) // RULE21
    else $error("prefetch exceeded four bytes");
  a_reset_fetch: assert property ($fell(reset_in)
      |-> r.code_addr == cebi_pkg::RESET_FETCH_ADDR) // RULE22
    else $error("wrong start address after reset");
  a_ale_only_t1: assert property (pins_out.ale
      |-> r.st == cebi_pkg::BS_T1 && mn) // RULE18
    else $error("address strobe outside T1");
endmodule

/* verif/cebi_mem_model.sv */
`timescale 1ns/1ps
module cebi_mem_model (
  input  wire logic                 ref_clk_in,
  input  wire logic                 reset_in,
  input  wire cebi_pkg::cebi_pins_t pins_in,
  input  wire logic [1:0]           wait_cnt_in,
  output logic                      ready_out,
  output logic [7:0]                data_out
);
  logic [19:0] addr;
  logic [2:0]  cnt;
  logic [7:0]  last;
  logic        rd_on;
  logic        ack_on;
  assign rd_on  = pins_in.rd_oe && !pins_in.rd_n;
  assign ack_on = pins_in.int_ack_strobe_n_oe && !pins_in.int_ack_strobe_n_n;
  // slow device: ready only after one strobe cycle more than the chosen count
  assign ready_out = cnt > {1'b0, wait_cnt_in};
  // released lines show the inverse, so stale data cannot pass as fresh
  // interrupt controller side answers every acknowledge with type 21
  assign data_out = ack_on ? 8'h21 : rd_on ? (addr[7:0] ^ 8'h5a) : ~last;
  always_ff @(posedge ref_clk_in) begin
    last <= reset_in ? 8'h00 : data_out;
    if (reset_in) begin
      cnt <= 3'h0;
    end else if (pins_in.ale) begin
      addr <= {pins_in.upper, pins_in.mid, pins_in.ad_out};
      cnt <= 3'h0;
    end else if (rd_on || ack_on || (pins_in.wr_oe && !pins_in.wr_n)) begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule

/* verif/cebi_bus_interface_tb.sv */
`timescale 1ns/1ps
module cebi_bus_interface_tb;
  logic clk = 1'b0, rst = 1'b1, hold = 1'b0, rv = 1'b0, rdy;
  logic [1:0] wc = 2'h0;
  logic nmi = 1'b0, irq = 1'b0, ien = 1'b0, bnd = 1'b0, tst = 1'b0;
  logic wi = 1'b0, fl = 1'b0, qr = 1'b0, ipv, ntk, itk, widle, qv;
  logic [7:0] md, mad, rdata, qb;
  logic [19:0] iptr;
  logic rvalid, ereq_rdy;
  cebi_pkg::cebi_req_t req = '0;
  cebi_pkg::cebi_pins_t p;
  int n_fail = 0, checks = 0;
  always #4 clk = ~clk;
  assign mad = p.ad_oe ? p.ad_out : md;
  cebi_bus_interface dut (.ref_clk_in(clk), .reset_in(rst),
    .config_select_in(1'b1), .ready_in(rdy), .maskable_irq_in(irq),
    .nmi_in(nmi), .test_in(tst), .hold_in(hold), .req_grant_a_in(1'b1),
    .req_grant_b_in(1'b1), .mux_addr_data_in(mad), .pins_out(p),
    .eu_req_in(req), .eu_req_valid_in(rv), .eu_req_ready_out(ereq_rdy),
    .irq_enable_in(ien), .instr_boundary_in(bnd), .wait_instr_in(wi),
    .flush_in(fl), .flush_addr_in(20'h00000), .queue_ready_in(qr),
    .queue_first_in(1'b0), .queue_byte_out(qb), .queue_valid_out(qv),
    .rdata_out(rdata), .rdata_valid_out(rvalid), .int_ptr_out(iptr),
    .int_ptr_valid_out(ipv), .irq_take_out(itk), .nmi_take_out(ntk),
    .wait_idle_out(widle));
  cebi_mem_model mem (.ref_clk_in(clk), .reset_in(rst), .pins_in(p),
    .wait_cnt_in(wc), .ready_out(rdy), .data_out(md));
  task conclude;
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task bound(input int i);
    if (i >= 60) begin
      n_fail++;
      conclude();
    end
  endtask
  task first_fetch;
    int i;
    for (i = 0; i < 60 && p.ale !== 1'b1; i++) @(negedge clk);
    bound(i);
    chk({p.upper, p.mid, p.ad_out}, cebi_pkg::RESET_FETCH_ADDR);
  endtask
  task xfer(input cebi_pkg::cebi_kind_t k, input logic [19:0] a,
            input logic [1:0] w);
    int i, n, z;
    logic [3:0] up;
    logic sp;
    @(posedge clk);
    wc <= w;
    req <= '{kind: k, addr: a, seg: cebi_pkg::SEG_DATA, wdata: 8'h00};
    rv <= 1'b1;
    @(negedge clk);
    for (i = 0; i < 60 && ereq_rdy !== 1'b1; i++) @(negedge clk);
    bound(i);
    @(posedge clk);
    rv <= 1'b0;
    n = 0;
    z = 0;
    for (i = 0; i < 60 && rvalid !== 1'b1; i++) begin
      @(negedge clk);
      if (p.ale === 1'b1) {up, sp} = {p.upper, p.space};
      if (p.rd_n === 1'b0 && p.rd_oe === 1'b1) n++;
      if (p.rd_n === 1'b0 && p.ad_oe === 1'b1) z++;
    end
    bound(i);
    chk(rdata, a[7:0] ^ 8'h5a);
    chk(n, w + 2);
    chk(z, 0);
    chk(up, k == cebi_pkg::CK_IO_RD ? 4'h0 : a[19:16]);
    chk(sp, k == cebi_pkg::CK_IO_RD);
  endtask
  task hold_off;
    int i;
    @(posedge clk);
    hold <= 1'b1;
    for (i = 0; i < 60 && p.hold_grant !== 1'b1; i++) @(negedge clk);
    bound(i);
    chk({p.ad_oe, p.rd_oe, p.xcvr_oe}, 3'h0);
    @(posedge clk);
    hold <= 1'b0;
    for (i = 0; i < 60 && p.hold_grant !== 1'b0; i++) @(negedge clk);
    bound(i);
  endtask
  task queue_ops;
    @(posedge clk);
    qr <= 1'b1;
    @(negedge clk);
    // head is the byte fetched from the reset address
    chk({qv, qb}, {1'b1, 8'haa});
    @(posedge clk);
    qr <= 1'b0;
    fl <= 1'b1;
    @(negedge clk);
    chk(p.qstate, 2'h3);
    @(posedge clk);
    fl <= 1'b0;
    @(negedge clk);
    chk({p.qstate, qv}, 3'h4);
  endtask
  task maskable_irq;
    int i;
    @(posedge clk);
    irq <= 1'b1;
    ien <= 1'b1;
    repeat (2) @(posedge clk);
    bnd <= 1'b1;
    @(posedge clk);
    bnd <= 1'b0;
    @(negedge clk);
    chk(itk, 1'b1);
    for (i = 0; i < 60 && ipv !== 1'b1; i++) @(negedge clk);
    bound(i);
    // model answers type 21, pointer is four times that
    chk(iptr, 20'h00084);
    @(posedge clk);
    irq <= 1'b0;
    nmi <= 1'b1;
    repeat (2) @(posedge clk);
    nmi <= 1'b0;
    @(posedge clk);
    bnd <= 1'b1;
    @(posedge clk);
    bnd <= 1'b0;
    @(negedge clk);
    chk({ntk, ipv, iptr[17:0]}, {2'h3, 18'h00008});
  endtask
  task wait_test;
    @(posedge clk);
    wi <= 1'b1;
    tst <= 1'b1;
    @(posedge clk);
    tst <= 1'b0;
    @(negedge clk);
    chk(widle, 1'b1);
    @(negedge clk);
    chk(widle, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    first_fetch();
    xfer(cebi_pkg::CK_MEM_RD, 20'h5a3c1, 2'h0);
    xfer(cebi_pkg::CK_MEM_RD, 20'hc0f37, 2'h3);
    xfer(cebi_pkg::CK_IO_RD, 20'h0a481, 2'h1);
    hold_off();
    xfer(cebi_pkg::CK_MEM_RD, 20'h30002, 2'h2);
    queue_ops();
    maskable_irq();
    wait_test();
    conclude();
  end
endmodule
